/* File: rtl/strap_clock_defines.vh */
// Functional notes
// - All logic is held in reset while the active-low chip reset is low.
// - The host interrupt output is high while an unmasked interrupt is pending.
// - Alternate scrambler seed reset is on when its strap is low, off if high.
// - With the source strap low the reference clock feeds the link PLL.
// - Source strap high and reference pin low selects the DSI receive clock.
// - Source strap high and reference pin high selects the DPI pixel clock.
// - The DSI divider strap matters only when the DSI source is selected.
// - Divider strap low divides the DSI clock by two and then by seven.
// - Divider strap high divides the DSI clock by two and then by nine.
// - The test pin high puts the device in test mode, low is normal.
`ifndef STRAP_CLOCK_DEFINES_VH
`define STRAP_CLOCK_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_STATUS    12'h000
`define REG_MASK      12'h004
`define REG_CTRL      12'h008
`define REG_STRAPS    12'h00C

// ----------------------------------------------------------------
// Source select encodings and fields
// ----------------------------------------------------------------
`define SRC_REF       2'h0
`define SRC_DSI       2'h1
`define SRC_DPI       2'h2
`define DIV_PRE       4'h2
`define DIV_SEVEN     4'h7
`define DIV_NINE      4'h9
`define EV_STRAP_CHG  0
`define EV_SOFT       1
`define EV_WIDTH      2
`define CTRL_SOFT_EV  0

`endif

/* File: rtl/strap_clock_source_select.v */
`timescale 1ns/1ps
`include "strap_clock_defines.vh"

module strap_clock_source_select (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  input  wire        chip_reset_low,
  // Straps from the board
  input  wire        pll_src_strap,
  input  wire        dsi_div_strap,
  input  wire        ref_clock_pin,
  input  wire        scrambler_seed_reset_off_strap,
  input  wire        test_pin,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Clock selection results
  output reg  [1:0]  pll_src_sel,
  output reg  [3:0]  dsi_post_div,
  output reg         dsi_div_tick,
  output reg         alt_scrambler_seed_reset,
  output reg         test_mode,
  // Host interrupt
  output wire        host_irq
);

  // ----------------------------------------------------------------
  // Reset and sampled straps
  // ----------------------------------------------------------------
  wire rst = srst | ~chip_reset_low;

  reg  [1:0] src_d;
  reg  [3:0] div_d;
  reg  [3:0] cnt_q;
  reg        pre_q;
  reg  [4:0] straps_q;
  reg        armed_q;

  always @* begin
    if (!pll_src_strap) begin
      src_d = `SRC_REF;
    end else if (!ref_clock_pin) begin
      src_d = `SRC_DSI;
    end else begin
      src_d = `SRC_DPI;
    end
    // Divider strap only counts with the DSI source selected.
    if (src_d == `SRC_DSI) begin
      div_d = dsi_div_strap ? `DIV_NINE : `DIV_SEVEN;
    end else begin
      div_d = `DIV_SEVEN;
    end
  end

  // Selection is refreshed continuously; the board keeps straps stable,
  // so a change is reported as an event rather than trusted silently.
  wire [4:0] straps_now = {test_pin, scrambler_seed_reset_off_strap,
                           ref_clock_pin, dsi_div_strap, pll_src_strap};
  wire strap_change = armed_q && (straps_now != straps_q);

  always @(posedge clk) begin
    if (rst) begin
      pll_src_sel              <= `SRC_REF;
      dsi_post_div             <= `DIV_SEVEN;
      alt_scrambler_seed_reset <= 1'b0;
      test_mode                <= 1'b0;
      straps_q                 <= 5'h00;
      armed_q                  <= 1'b0;
    end else begin
      pll_src_sel              <= src_d;
      dsi_post_div             <= div_d;
      alt_scrambler_seed_reset <= ~scrambler_seed_reset_off_strap;
      test_mode                <= test_pin;
      straps_q                 <= straps_now;
      armed_q                  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // DSI clock divider: by two, then by seven or nine
  // ----------------------------------------------------------------
  // The divider runs on clk as an enable pulse; the analog PLL path
  // itself sits outside this block.
  always @(posedge clk) begin
    if (rst) begin
      pre_q        <= 1'b0;
      cnt_q        <= 4'h0;
      dsi_div_tick <= 1'b0;
    end else begin
      dsi_div_tick <= 1'b0;
      if (pll_src_sel == `SRC_DSI) begin
        pre_q <= ~pre_q;
        if (pre_q) begin
          if (cnt_q == dsi_post_div - 4'h1) begin
            cnt_q        <= 4'h0;
            dsi_div_tick <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end else begin
        pre_q <= 1'b0;
        cnt_q <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB registers and interrupt
  // ----------------------------------------------------------------
  reg  [`EV_WIDTH-1:0] status_q;
  reg  [`EV_WIDTH-1:0] mask_q;
  reg                  soft_q;

  wire wr_en = psel & penable & pwrite;
  wire hit   = (paddr == `REG_STATUS) || (paddr == `REG_MASK) ||
               (paddr == `REG_CTRL) || (paddr == `REG_STRAPS);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  wire soft_ev = wr_en && (paddr == `REG_CTRL) && pwdata[`CTRL_SOFT_EV];
  wire [`EV_WIDTH-1:0] ev_set;
  assign ev_set[`EV_STRAP_CHG] = strap_change;
  assign ev_set[`EV_SOFT]      = soft_ev;
  wire [`EV_WIDTH-1:0] w1c =
    (wr_en && paddr == `REG_STATUS) ? pwdata[`EV_WIDTH-1:0]
                                    : {`EV_WIDTH{1'b0}};

  always @(posedge clk) begin
    if (rst) begin
      status_q <= {`EV_WIDTH{1'b0}};
      mask_q   <= {`EV_WIDTH{1'b0}};
      soft_q   <= 1'b0;
      prdata   <= 32'h0000_0000;
    end else begin
      // Set wins over a simultaneous write-one-to-clear.
      status_q <= (status_q & ~w1c) | ev_set;
      if (wr_en && paddr == `REG_MASK) begin
        mask_q <= pwdata[`EV_WIDTH-1:0];
      end
      if (wr_en && paddr == `REG_CTRL) begin
        soft_q <= pwdata[`CTRL_SOFT_EV];
      end
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `REG_STATUS: prdata <= {30'h0000_0000, status_q};
          `REG_MASK:   prdata <= {30'h0000_0000, mask_q};
          `REG_CTRL:   prdata <= {31'h0000_0000, soft_q};
          `REG_STRAPS: prdata <= {24'h00_0000, test_mode,
                                  alt_scrambler_seed_reset,
                                  dsi_post_div, pll_src_sel};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign host_irq = |(status_q & mask_q);

endmodule

/* File: tb/strap_clock_monitor.sv */
`timescale 1ns/1ps
module strap_clock_monitor (
  // Clock, reset and straps
  input wire       clk, srst, chip_reset_low, pll_src_strap,
  input wire       dsi_div_strap, ref_clock_pin, test_pin,
  input wire       scrambler_seed_reset_off_strap,
  // Selection results
  input wire [1:0] pll_src_sel,
  input wire [3:0] dsi_post_div,
  input wire       dsi_div_tick, alt_scrambler_seed_reset,
  input wire       test_mode, host_irq
);
  // ----
  // Strap decode checks
  // ----
  wire dsi = pll_src_strap & ~ref_clock_pin;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  reset_clears_a: assert property (!chip_reset_low |=>
    pll_src_sel == 2'h0 && !test_mode && !host_irq) else $error("reset");
  ref_source_a: assert property (chip_reset_low && !pll_src_strap
    |=> pll_src_sel == 2'h0) else $error("ref source");
  dsi_source_a: assert property (chip_reset_low && dsi
    |=> pll_src_sel == 2'h1) else $error("dsi source");
  dpi_source_a: assert property (chip_reset_low && pll_src_strap
    && ref_clock_pin |=> pll_src_sel == 2'h2) else $error("dpi source");
  div_ignored_a: assert property (chip_reset_low && !dsi
    |=> dsi_post_div == 4'h7) else $error("divider not ignored");
  div_ratio_a: assert property (chip_reset_low && dsi |=>
    dsi_post_div == ($past(dsi_div_strap) ? 4'h9 : 4'h7))
    else $error("divider ratio");
  seed_reset_a: assert property (chip_reset_low |=>
    alt_scrambler_seed_reset == !$past(scrambler_seed_reset_off_strap))
    else $error("seed reset");
  test_mode_a: assert property (chip_reset_low |=>
    test_mode == $past(test_pin)) else $error("test mode");
  cover property (dsi_div_tick);
  cover property (host_irq);
  cover property (pll_src_sel == 2'h2);
endmodule
bind strap_clock_source_select strap_clock_monitor mon (.*);

/* File: tb/strap_board_model.sv */
`timescale 1ns/1ps
module strap_board_model (
  input  wire  clk,
  output logic chip_reset_low,
  output logic pll_src_strap, dsi_div_strap, ref_clock_pin,
  output logic scrambler_seed_reset_off_strap, test_pin
);
  // ----
  // Strap sequencing
  // ----
  initial {chip_reset_low, pll_src_strap, dsi_div_strap, ref_clock_pin,
    scrambler_seed_reset_off_strap, test_pin} = 6'h20;
  // Straps move only under reset, so the source never changes in use.
  task automatic apply(input logic [4:0] s);
    chip_reset_low <= 1'b0;
    @(posedge clk);
    {pll_src_strap, dsi_div_strap, ref_clock_pin,
      scrambler_seed_reset_off_strap, test_pin} <= s;
    @(posedge clk);
    chip_reset_low <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule

/* File: tb/strap_clock_source_select_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
  end end
module strap_clock_source_select_tb;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0] pll_src_sel;
  logic [3:0] dsi_post_div;
  logic pready, pslverr, dsi_div_tick, alt_scrambler_seed_reset, err;
  logic test_mode, host_irq, chip_reset_low, pll_src_strap, test_pin;
  logic dsi_div_strap, ref_clock_pin, scrambler_seed_reset_off_strap;
  int miscompares = 0, samples_checked = 0;
  strap_clock_source_select dut (.*);
  strap_board_model board (.*);
  initial forever #12.5 clk = ~clk;
  // ----
  // Bus and scenarios
  // ----
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic s_div;
    int n;
    for (int k = 0; k < 2; k++) begin
      board.apply({1'b1, k[0], 3'b000});
      do @(posedge clk); while (dsi_div_tick !== 1'b1);
      n = 0;
      do begin @(posedge clk); n++; end while (dsi_div_tick !== 1'b1);
      `CHK(n, k ? 18 : 14)
    end
  endtask
  task automatic s_straps;
    logic [1:0] src;
    for (int i = 0; i < 32; i++) begin
      board.apply(i[4:0]);
      src = !i[4] ? 2'h0 : i[2] ? 2'h2 : 2'h1;
      `CHK(pll_src_sel, src)
      `CHK(dsi_post_div, (src == 2'h1 && i[3]) ? 4'h9 : 4'h7)
      `CHK(alt_scrambler_seed_reset, !i[1])
      `CHK(test_mode, i[0])
    end
  endtask
  task automatic s_irq;
    apb(1, 12'h004, 32'h0000_0002);
    apb(1, 12'h008, 32'h0000_0001);
    apb(1, 12'h008, 32'h0000_0000);
    `CHK(host_irq, 1'b1)
    apb(0, 12'h000, 0);
    `CHK(rd[1], 1'b1)
    apb(1, 12'h000, 32'h0000_0002);
    @(posedge clk);
    `CHK(host_irq, 1'b0)
    apb(1, 12'h004, 0);
    apb(1, 12'h008, 32'h0000_0001);
    @(posedge clk);
    `CHK(host_irq, 1'b0)
    apb(0, 12'h010, 0);
    `CHK({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
  endtask
  task automatic summarize;
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    s_straps;
    s_div;
    s_irq;
    summarize;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize;
  end
endmodule
